/* File: hw/ddrc_pkg.sv */
/*
  Constants, encodings and register map of the DDR2 command controller.
  Assumes a 10 MHz system clock; the memory clock is derived by dividing it by two.
*/
package ddrc_pkg;
  // System clock and memory clock
  localparam int CLK_PERIOD_NS = 100;
  localparam int CK_DIV = 2;
  // Delays in their own units
  localparam int MODE_SET_WAIT_CK = 2;
  localparam int DLL_LOCK_CK = 200;
  localparam int ROW_CLOSE_NS = 15;
  localparam int ROW_TO_COL_NS = 15;
  localparam int REFRESH_NS = 105;
  localparam int SELF_EXIT_NS = 200;
  // Derived counts in system clock cycles, least times rounded up
  localparam int MODE_SET_WAIT_CYC = MODE_SET_WAIT_CK * CK_DIV;
  localparam int DLL_LOCK_CYC = DLL_LOCK_CK * CK_DIV;
  localparam int ROW_CLOSE_CYC = (ROW_CLOSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int ROW_TO_COL_CYC = (ROW_TO_COL_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int REFRESH_CYC = (REFRESH_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int SELF_EXIT_CYC = (SELF_EXIT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int SYNC_STAGES = 2;
  // Register offsets
  localparam logic [7:0] REG_CMD = 8'h00;
  localparam logic [7:0] REG_MODE = 8'h04;
  localparam logic [7:0] REG_WDATA = 8'h08;
  localparam logic [7:0] REG_STATUS = 8'h0c;
  localparam logic [7:0] REG_RDATA = 8'h10;
  localparam logic [7:0] REG_CFG = 8'h14;
  // Field positions
  localparam int CMD_OP_LSB = 0;
  localparam int CMD_BANK_LSB = 4;
  localparam int CMD_ADDR_LSB = 6;
  localparam int WDATA_MASK_LSB = 16;
  localparam int ST_BUSY = 0;
  localparam int ST_REFUSED = 1;
  localparam int ST_SELF = 2;
  localparam int ST_DLL_WAIT = 3;
  localparam int ST_OPEN_LSB = 4;
  // Mode word fields
  localparam int MODE_BT_BIT = 3;
  localparam int MODE_TEST_BIT = 7;
  localparam int MODE_DLL_BIT = 8;
  localparam int AUTO_PRE_BIT = 10;
  localparam logic [2:0] BL_CODE4 = 3'h2;
  localparam logic [2:0] BL_CODE8 = 3'h3;
  localparam logic [2:0] CL_MIN = 3'h3;
  // Reset values
  localparam logic [12:0] MODE_RESET = 13'h0032;
  localparam logic [2:0] AL_RESET = 3'h0;
  // Pin encodings {cs_n, ras_n, cas_n, we_n}
  localparam logic [3:0] PIN_NOP = 4'h7;
  localparam logic [3:0] PIN_MODE = 4'h0;
  localparam logic [3:0] PIN_ACT = 4'h3;
  localparam logic [3:0] PIN_READ = 4'h5;
  localparam logic [3:0] PIN_WRITE = 4'h4;
  localparam logic [3:0] PIN_PRE = 4'h2;
  localparam logic [3:0] PIN_REF = 4'h1;
  // Bus answers
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef enum logic [3:0] {
    OP_NOP, OP_MODE_LOAD, OP_ACTIVATE, OP_READ, OP_WRITE,
    OP_PRECHARGE, OP_REFRESH, OP_SELF_ENTER, OP_SELF_EXIT
  } ddrc_op_t;
endpackage

/* File: hw/ddrc_sync.sv */
/*
  Two-stage synchroniser for a vector of unrelated level inputs.
  Assumes each bit may change at any time relative to sys_clk.
*/
`timescale 1ns/1ps
module ddrc_sync #(
  parameter int WIDTH = 1
) (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic rst_n,
  // Data
  input wire logic [WIDTH-1:0] d,
  output logic [WIDTH-1:0] q
);
  logic [WIDTH-1:0] meta_r;

  // First stage feeds only the second stage
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      meta_r <= '0;
      q <= '0;
    end else begin
      meta_r <= d;
      q <= meta_r;
    end
  end
endmodule

/* File: hw/ddrc_ctrl.sv */
/*
  DDR2 command controller: takes commands over AXI4-Lite and drives a DDR2 device's pins.
  Assumes the device samples commands on the rising memory clock; data beats are taken
  once per system cycle, which is one per memory clock edge. Strobes are not generated.
*/
// Added by the designer: register access over AXI4-Lite and the register offsets.
// How it works
// - Idle command slots carry the no-operation encoding, leaving work in progress alone.
// - Mode load only with all banks idle; then wait the mode set delay.
// - Activate opens a row; another row needs a precharge first.
// - Reads and writes may go early by the posted extra latency.
// - Precharge closes one or all banks; activate waits the row close time.
// - Reads and writes go only to a bank with an open row.
// - Refresh only with all banks idle, one per command, address ignored.
// - Self refresh is refresh encoding with clock enable low; DLL restarts on exit.
// - Every mode load supplies the whole word.
// - Mode bit seven set selects test mode and is never sent.
// - No read until 200 clocks after any DLL reset.
`timescale 1ns/1ps
module ddrc_ctrl
  import ddrc_pkg::*;
(
  // Clock and reset
  input wire logic sys_clk,
  input wire logic rstn,
  // AXI4-Lite write channels
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  // AXI4-Lite read channels
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // Memory pins
  output logic ddr_ck,
  output logic ddr_cke,
  output logic ddr_cs_n,
  output logic ddr_ras_n,
  output logic ddr_cas_n,
  output logic ddr_we_n,
  output logic [1:0] ddr_ba,
  output logic [12:0] ddr_addr,
  output logic [1:0] ddr_dm,
  output logic [15:0] ddr_dq_o,
  output logic ddr_dq_oe,
  input wire logic [15:0] ddr_dq_i
);
  typedef enum logic [2:0] {S_IDLE, S_ISSUE, S_WAIT, S_DATA, S_SELF} ddrc_state_t;

  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw, input logic [3:0] strb);
    logic [31:0] res;
    res = old;
    for (int i = 0; i < 4; i++) begin
      if (strb[i]) begin
        res[8*i +: 8] = nw[8*i +: 8];
      end
    end
    return res;
  endfunction

  logic [1:0] rst_sync_r;
  logic rst_n_s;
  logic ck_r;
  logic fall_evt;
  ddrc_state_t state_r;
  ddrc_op_t op_r;
  logic [1:0] bank_r;
  logic [12:0] addr_r;
  logic [12:0] mode_r;
  logic [2:0] al_r;
  logic [15:0] wdata_r;
  logic [1:0] wmask_r;
  logic [31:0] rdata_r;
  logic refused_r;
  logic [3:0] open_r;
  logic [7:0] act_cnt_r [4];
  logic [7:0] close_cnt_r [4];
  logic [9:0] dll_cnt_r;
  logic [7:0] wait_r;
  logic [5:0] lat_r;
  logic [3:0] beat_r;
  logic aw_got_r, w_got_r;
  logic [7:0] aw_addr_r;
  logic [31:0] w_data_r;
  logic [3:0] w_strb_r;
  logic wr_do;
  logic cmd_we;
  logic cmd_ok;
  ddrc_op_t cmd_op;
  logic [1:0] cmd_bank;
  logic [12:0] cmd_addr;
  logic issue;
  logic [15:0] dq_s;
  logic [3:0] bl_beats;
  logic [5:0] rl_ck;

  // Reset release through two flip-flops
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      rst_sync_r <= 2'h0;
    end else begin
      rst_sync_r <= {rst_sync_r[0], 1'b1};
    end
  end
  assign rst_n_s = rst_sync_r[1];

  // Memory clock by dividing sys_clk by two; pins change when it falls
  always_ff @(posedge sys_clk or negedge rst_n_s) begin
    if (!rst_n_s) begin
      ck_r <= 1'b0;
    end else begin
      ck_r <= ~ck_r;
    end
  end
  assign ddr_ck = ck_r;
  assign fall_evt = ck_r;
  assign issue = (state_r == S_ISSUE) && fall_evt;

  ddrc_sync #(.WIDTH(16)) u_dq_sync (
    .sys_clk(sys_clk),
    .rst_n(rst_n_s),
    .d(ddr_dq_i),
    .q(dq_s)
  );

  // Burst length and CAS latency from the mode shadow; additive latency from the CFG register
  assign bl_beats = (mode_r[2:0] == BL_CODE8) ? 4'h8 : 4'h4;
  assign rl_ck = 6'(mode_r[6:4]) + 6'(al_r);

  // AXI4-Lite slave; one write and one read at a time
  assign s_axi_awready = !aw_got_r && !s_axi_bvalid;
  assign s_axi_wready = !w_got_r && !s_axi_bvalid;
  assign s_axi_arready = !s_axi_rvalid;
  assign wr_do = aw_got_r && w_got_r && !s_axi_bvalid;
  assign cmd_we = wr_do && (aw_addr_r == REG_CMD);
  assign cmd_op = ddrc_op_t'(w_data_r[CMD_OP_LSB +: 4]);
  assign cmd_bank = w_data_r[CMD_BANK_LSB +: 2];
  assign cmd_addr = w_data_r[CMD_ADDR_LSB +: 13];

  always_ff @(posedge sys_clk or negedge rst_n_s) begin
    if (!rst_n_s) begin
      aw_got_r <= 1'b0;
      w_got_r <= 1'b0;
      aw_addr_r <= 8'h00;
      w_data_r <= 32'h0;
      w_strb_r <= 4'h0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= RESP_OKAY;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_got_r <= 1'b1;
        aw_addr_r <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_got_r <= 1'b1;
        w_data_r <= s_axi_wdata;
        w_strb_r <= s_axi_wstrb;
      end
      if (wr_do) begin
        aw_got_r <= 1'b0;
        w_got_r <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= (aw_addr_r == REG_CMD || aw_addr_r == REG_WDATA || aw_addr_r == REG_STATUS ||
                        aw_addr_r == REG_CFG) ? RESP_OKAY : RESP_SLVERR;
      end else if (s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  always_ff @(posedge sys_clk or negedge rst_n_s) begin
    if (!rst_n_s) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0;
      s_axi_rresp <= RESP_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rresp <= RESP_OKAY;
      unique case (s_axi_araddr)
        REG_MODE: s_axi_rdata <= 32'(mode_r);
        REG_WDATA: s_axi_rdata <= {14'h0, wmask_r, wdata_r};
        REG_STATUS: s_axi_rdata <= 32'({open_r, dll_cnt_r != 10'h0, state_r == S_SELF, refused_r,
                                        state_r != S_IDLE && state_r != S_SELF});
        REG_RDATA: s_axi_rdata <= rdata_r;
        REG_CFG: s_axi_rdata <= 32'(al_r);
        default: begin
          s_axi_rdata <= 32'h0;
          s_axi_rresp <= RESP_SLVERR;
        end
      endcase
    end else if (s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end

  // Software settings
  always_ff @(posedge sys_clk or negedge rst_n_s) begin
    if (!rst_n_s) begin
      wdata_r <= 16'h0;
      wmask_r <= 2'h0;
      al_r <= AL_RESET;
    end else if (wr_do && aw_addr_r == REG_WDATA) begin
      {wmask_r, wdata_r} <= 18'(merge({14'h0, wmask_r, wdata_r}, w_data_r, w_strb_r));
    end else if (wr_do && aw_addr_r == REG_CFG) begin
      al_r <= 3'(merge(32'(al_r), w_data_r, w_strb_r));
    end
  end

  // Whether a new command may go to the pins now
  always_comb begin
    cmd_ok = 1'b0;
    if (state_r == S_SELF) begin
      cmd_ok = (cmd_op == OP_SELF_EXIT);
    end else if (state_r == S_IDLE) begin
      unique case (cmd_op)
        OP_NOP, OP_PRECHARGE: cmd_ok = 1'b1;
        OP_MODE_LOAD: cmd_ok = (open_r == 4'h0) && (cmd_bank != 2'h0 || (!cmd_addr[MODE_TEST_BIT] &&
                               (cmd_addr[2:0] == BL_CODE4 || cmd_addr[2:0] == BL_CODE8) && cmd_addr[6:4] >= CL_MIN));
        OP_ACTIVATE: cmd_ok = !open_r[cmd_bank] && close_cnt_r[cmd_bank] == 8'h0;
        OP_READ: cmd_ok = open_r[cmd_bank] && dll_cnt_r == 10'h0 &&
                          act_cnt_r[cmd_bank] <= 8'(CK_DIV) * 8'(al_r);
        OP_WRITE: cmd_ok = open_r[cmd_bank] && act_cnt_r[cmd_bank] <= 8'(CK_DIV) * 8'(al_r);
        OP_REFRESH, OP_SELF_ENTER: cmd_ok = (open_r == 4'h0) && close_cnt_r[0] == 8'h0 && close_cnt_r[1] == 8'h0 &&
                                            close_cnt_r[2] == 8'h0 && close_cnt_r[3] == 8'h0;
        default: cmd_ok = 1'b0;
      endcase
    end
  end

  // Command sequencer
  always_ff @(posedge sys_clk or negedge rst_n_s) begin
    if (!rst_n_s) begin
      state_r <= S_IDLE;
      op_r <= OP_NOP;
      bank_r <= 2'h0;
      addr_r <= 13'h0;
      wait_r <= 8'h0;
      lat_r <= 6'h0;
      beat_r <= 4'h0;
    end else begin
      unique case (state_r)
        S_IDLE, S_SELF: begin
          if (cmd_we && cmd_ok) begin
            state_r <= S_ISSUE;
            op_r <= cmd_op;
            bank_r <= cmd_bank;
            addr_r <= cmd_addr;
          end
        end
        S_ISSUE: begin
          if (fall_evt) begin
            state_r <= S_WAIT;
            wait_r <= 8'(CK_DIV - 1);
            unique case (op_r)
              OP_MODE_LOAD: wait_r <= 8'(MODE_SET_WAIT_CYC - 1);
              OP_REFRESH: wait_r <= 8'(REFRESH_CYC - 1);
              OP_SELF_EXIT: wait_r <= 8'(SELF_EXIT_CYC - 1);
              OP_SELF_ENTER: state_r <= S_SELF;
              OP_READ: begin
                state_r <= S_DATA;
                lat_r <= 6'(CK_DIV) * rl_ck + 6'(SYNC_STAGES);
                beat_r <= bl_beats;
              end
              OP_WRITE: begin
                state_r <= S_DATA;
                lat_r <= 6'(CK_DIV) * (rl_ck - 6'h1);
                beat_r <= bl_beats;
              end
              default: wait_r <= 8'(CK_DIV - 1);
            endcase
          end
        end
        S_WAIT: begin
          if (wait_r != 8'h0) begin
            wait_r <= wait_r - 8'h1;
          end else begin
            state_r <= S_IDLE;
          end
        end
        S_DATA: begin
          if (lat_r != 6'h0) begin
            lat_r <= lat_r - 6'h1;
          end else if (beat_r != 4'h1) begin
            beat_r <= beat_r - 4'h1;
          end else begin
            state_r <= S_WAIT;
            wait_r <= 8'(CK_DIV - 1);
          end
        end
      endcase
    end
  end

  // Mode shadow and DLL lock wait; the reset bit never stays set
  always_ff @(posedge sys_clk or negedge rst_n_s) begin
    if (!rst_n_s) begin
      mode_r <= MODE_RESET;
      dll_cnt_r <= 10'h0;
    end else begin
      if (issue && op_r == OP_MODE_LOAD && bank_r == 2'h0) begin
        mode_r <= addr_r & ~(13'h1 << MODE_DLL_BIT);
      end
      if ((issue && op_r == OP_MODE_LOAD && bank_r == 2'h0 && addr_r[MODE_DLL_BIT]) ||
          (issue && op_r == OP_SELF_EXIT)) begin
        dll_cnt_r <= 10'(DLL_LOCK_CYC);
      end else if (dll_cnt_r != 10'h0) begin
        dll_cnt_r <= dll_cnt_r - 10'h1;
      end
    end
  end

  // Per-bank row state and timers
  always_ff @(posedge sys_clk or negedge rst_n_s) begin
    if (!rst_n_s) begin
      open_r <= 4'h0;
      for (int b = 0; b < 4; b++) begin
        act_cnt_r[b] <= 8'h0;
        close_cnt_r[b] <= 8'h0;
      end
    end else begin
      for (int b = 0; b < 4; b++) begin
        if (act_cnt_r[b] != 8'h0) begin
          act_cnt_r[b] <= act_cnt_r[b] - 8'h1;
        end
        if (close_cnt_r[b] != 8'h0) begin
          close_cnt_r[b] <= close_cnt_r[b] - 8'h1;
        end
        if (issue && op_r == OP_ACTIVATE && bank_r == 2'(b)) begin
          open_r[b] <= 1'b1;
          act_cnt_r[b] <= 8'(ROW_TO_COL_CYC);
        end
        if (issue && op_r == OP_PRECHARGE && (addr_r[AUTO_PRE_BIT] || bank_r == 2'(b))) begin
          open_r[b] <= 1'b0;
          close_cnt_r[b] <= 8'(ROW_CLOSE_CYC);
        end
        if (state_r == S_DATA && lat_r == 6'h0 && beat_r == 4'h1 && addr_r[AUTO_PRE_BIT] && bank_r == 2'(b)) begin
          open_r[b] <= 1'b0;
          close_cnt_r[b] <= 8'(ROW_CLOSE_CYC) + ((op_r == OP_WRITE) ?
                            8'(CK_DIV) * (8'(mode_r[11:9]) + 8'h1) : 8'h0);
        end
      end
    end
  end

  // Command pins, refreshed while the memory clock falls
  always_ff @(posedge sys_clk or negedge rst_n_s) begin
    if (!rst_n_s) begin
      {ddr_cs_n, ddr_ras_n, ddr_cas_n, ddr_we_n} <= PIN_NOP;
      ddr_cke <= 1'b0;
      ddr_ba <= 2'h0;
      ddr_addr <= 13'h0;
    end else if (fall_evt) begin
      ddr_cke <= issue ? (op_r != OP_SELF_ENTER) : (state_r != S_SELF);
      ddr_ba <= issue ? bank_r : 2'h0;
      ddr_addr <= issue ? addr_r : 13'h0;
      {ddr_cs_n, ddr_ras_n, ddr_cas_n, ddr_we_n} <= PIN_NOP;
      if (issue) begin
        unique case (op_r)
          OP_MODE_LOAD: {ddr_cs_n, ddr_ras_n, ddr_cas_n, ddr_we_n} <= PIN_MODE;
          OP_ACTIVATE: {ddr_cs_n, ddr_ras_n, ddr_cas_n, ddr_we_n} <= PIN_ACT;
          OP_READ: {ddr_cs_n, ddr_ras_n, ddr_cas_n, ddr_we_n} <= PIN_READ;
          OP_WRITE: {ddr_cs_n, ddr_ras_n, ddr_cas_n, ddr_we_n} <= PIN_WRITE;
          OP_PRECHARGE: {ddr_cs_n, ddr_ras_n, ddr_cas_n, ddr_we_n} <= PIN_PRE;
          OP_REFRESH, OP_SELF_ENTER: {ddr_cs_n, ddr_ras_n, ddr_cas_n, ddr_we_n} <= PIN_REF;
          default: {ddr_cs_n, ddr_ras_n, ddr_cas_n, ddr_we_n} <= PIN_NOP;
        endcase
      end
    end
  end

  // Data beats; the same word and mask go out on every write beat
  always_ff @(posedge sys_clk or negedge rst_n_s) begin
    if (!rst_n_s) begin
      ddr_dq_o <= 16'h0;
      ddr_dq_oe <= 1'b0;
      ddr_dm <= 2'h3;
      rdata_r <= 32'h0;
    end else begin
      ddr_dq_oe <= state_r == S_DATA && op_r == OP_WRITE && lat_r == 6'h0;
      ddr_dq_o <= wdata_r;
      ddr_dm <= (state_r == S_DATA && op_r == OP_WRITE) ? wmask_r : 2'h3;
      if (state_r == S_DATA && op_r == OP_READ && lat_r == 6'h0 && beat_r > bl_beats - 4'h2) begin
        rdata_r <= {dq_s, rdata_r[31:16]};
      end
    end
  end

  // Refused flag: a refusal in the same cycle as the clear wins
  always_ff @(posedge sys_clk or negedge rst_n_s) begin
    if (!rst_n_s) begin
      refused_r <= 1'b0;
    end else begin
      refused_r <= (cmd_we && !cmd_ok) ||
                   (refused_r && !(wr_do && aw_addr_r == REG_STATUS && w_strb_r[0] && w_data_r[ST_REFUSED]));
    end
  end

  default clocking @(posedge sys_clk); endclocking
  default disable iff (!rst_n_s);

  a_idle_nop: assert property (state_r == S_IDLE && $past(state_r) == S_IDLE && fall_evt |=>
    {ddr_cs_n, ddr_ras_n, ddr_cas_n, ddr_we_n} == PIN_NOP) else $error("idle slot not a no-operation");
  a_mode_idle: assert property (issue && op_r == OP_MODE_LOAD |-> open_r == 4'h0
    ##1 (state_r == S_WAIT)[*4]) else $error("mode load with open bank or short wait");
  a_act_closed: assert property (issue && op_r == OP_ACTIVATE |->
    !open_r[bank_r] && close_cnt_r[bank_r] == 8'h0) else $error("activate to busy bank");
  a_rw_open: assert property (issue && (op_r == OP_READ || op_r == OP_WRITE) |->
    open_r[bank_r] && act_cnt_r[bank_r] <= 8'(CK_DIV) * 8'(al_r)) else $error("column command to closed row");
  a_pre_close: assert property (issue && op_r == OP_PRECHARGE |=> !open_r[bank_r]
    && close_cnt_r[bank_r] != 8'h0) else $error("precharge did not close bank");
  a_dll_read: assert property (issue && op_r == OP_READ |-> dll_cnt_r == 10'h0)
    else $error("read during DLL lock wait");
  a_test_mode: assert property (issue && op_r == OP_MODE_LOAD && bank_r == 2'h0 |->
    !addr_r[MODE_TEST_BIT] ##1 !mode_r[MODE_DLL_BIT]) else $error("test mode or stuck DLL bit");
  a_ref_idle: assert property (issue && op_r == OP_REFRESH |-> open_r == 4'h0
    ##1 ddr_cke && {ddr_cs_n, ddr_ras_n, ddr_cas_n, ddr_we_n} == PIN_REF) else $error("bad refresh");
  a_self_cke: assert property (state_r == S_SELF && !$rose(state_r == S_SELF) |-> !ddr_cke)
    else $error("clock enable high in self refresh");
  a_mask_beat: assert property (ddr_dq_oe |-> ddr_dm == wmask_r && ddr_dq_o == wdata_r)
    else $error("write beat without programmed mask");
endmodule

/* File: dv/ddrc_dev_model.sv */
/* DDR2 device model: mode register, open rows, one stored data word.
   Assumes pins settle before each rising ck; sys_clk only strobes write beats. */
`timescale 1ns/1ps
module ddrc_dev_model
  import ddrc_pkg::*;
(
  // Clocks
  input wire logic sys_clk,
  input wire logic ck,
  // Command
  input wire logic cke,
  input wire logic [3:0] cmd,
  input wire logic [1:0] ba,
  input wire logic [12:0] addr,
  // Data
  input wire logic [1:0] dm,
  input wire logic [15:0] dq_o,
  input wire logic dq_oe,
  output logic [15:0] dq_i,
  // State seen by the bench
  output logic [12:0] mode_r,
  output logic [3:0] open_r,
  output int viol
);
  logic [15:0] mem_r = 16'h0000;
  int rd_t = 0;
  int dll_t = 0;
  initial {mode_r, open_r, viol} = '0;
  // Outside the read window the inverse shows, so stale data never passes
  assign dq_i = (rd_t >= mode_r[6:4] - 1 && rd_t <= mode_r[6:4] + 3) ? mem_r : ~mem_r;
  always @(negedge sys_clk) begin
    if (dq_oe && !dm[0]) mem_r[7:0] <= dq_o[7:0];
    if (dq_oe && !dm[1]) mem_r[15:8] <= dq_o[15:8];
  end
  always @(posedge ck) begin
    dll_t <= dll_t + 1;
    rd_t <= (rd_t > 0) ? rd_t + 1 : 0;
    if (cke) begin
      case (cmd)
        PIN_MODE: begin
          if (open_r != 0) viol <= viol + 1;
          if (ba == 2'h0 && !addr[MODE_TEST_BIT]) mode_r <= addr & 13'h1eff;
          if (ba == 2'h0 && addr[MODE_DLL_BIT]) dll_t <= 0;
        end
        PIN_ACT: begin
          if (open_r[ba]) viol <= viol + 1;
          open_r[ba] <= 1'b1;
        end
        PIN_READ, PIN_WRITE: begin
          if (!open_r[ba] || (cmd[0] && dll_t < DLL_LOCK_CK)) viol <= viol + 1;
          if (cmd[0]) rd_t <= 1;
          if (addr[AUTO_PRE_BIT]) open_r[ba] <= 1'b0;
        end
        PIN_PRE: open_r <= addr[AUTO_PRE_BIT] ? 4'h0 : open_r & ~(4'h1 << ba);
        PIN_REF: if (open_r != 0) viol <= viol + 1;
        default: ;
      endcase
    end else dll_t <= 0;
  end
endmodule

/* File: dv/ddrc_ctrl_tb.sv */
/* Bench for the DDR2 command controller: AXI4-Lite tasks and command sequences.
   Assumes the device model on the pins and a 10 MHz system clock. */
`timescale 1ns/1ps
module ddrc_ctrl_tb
  import ddrc_pkg::*;
;
  logic sys_clk = 1'b0;
  logic rstn = 1'b0;
  logic [7:0] awaddr = 8'h00, araddr = 8'h00;
  logic [31:0] wdata = 32'h0, rdata;
  logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
  logic awready, wready, bvalid, arready, rvalid, ck, cke, dq_oe;
  logic [3:0] pins, open_r;
  logic [1:0] bresp, rresp, ba, dm;
  logic [12:0] addr, mode_r;
  logic [15:0] dq_o, dq_i;
  int viol, mismatches = 0, total_checks = 0;
  always #50 sys_clk = ~sys_clk;
  ddrc_ctrl uut (.sys_clk(sys_clk), .rstn(rstn), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
    .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(4'hf), .s_axi_wvalid(wvalid),
    .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
    .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready), .ddr_ck(ck), .ddr_cke(cke),
    .ddr_cs_n(pins[3]), .ddr_ras_n(pins[2]), .ddr_cas_n(pins[1]), .ddr_we_n(pins[0]), .ddr_ba(ba),
    .ddr_addr(addr), .ddr_dm(dm), .ddr_dq_o(dq_o), .ddr_dq_oe(dq_oe), .ddr_dq_i(dq_i));
  ddrc_dev_model dev (.sys_clk(sys_clk), .ck(ck), .cke(cke), .cmd(pins), .ba(ba), .addr(addr),
    .dm(dm), .dq_o(dq_o), .dq_oe(dq_oe), .dq_i(dq_i), .mode_r(mode_r), .open_r(open_r), .viol(viol));
  task automatic check(input logic [33:0] seen, input logic [33:0] exp);
    total_checks++;
    if (seen !== exp) begin
      mismatches++;
      $display("CHECK FAILED at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask
  // Column of beat i; sequential order wraps inside the starting nibble, and in BL8 column bit 2 also toggles with i[2]
  function automatic logic [2:0] beat_col(input logic [2:0] st, input logic [2:0] i, input logic il, input logic bl8);
    logic [2:0] c;
    c = il ? st ^ i : {st[2] ^ i[2], 2'(st[1:0] + i[1:0])};
    return bl8 ? c : {st[2], c[1:0]};
  endfunction
  task automatic summarize;
    $display("checks %0d mismatches %0d", total_checks, mismatches);
    if (mismatches == 0 && total_checks > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  task automatic timeout_hit;
    mismatches++;
    $display("CHECK FAILED at %0t: wait timed out", $time);
    summarize();
  endtask
  // Each task starts one edge late so no strobe is set twice in one time step
  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
    int n = 0;
    @(posedge sys_clk);
    awaddr <= a;
    wdata <= d;
    {awvalid, wvalid, bready} <= 3'h7;
    do begin
      @(posedge sys_clk);
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
      n++;
    end while (!bvalid && n < 200);
    check(bresp, er);
    bready <= 1'b0;
    if (n >= 200) timeout_hit();
  endtask
  task automatic rd(input logic [7:0] a, output logic [33:0] d);
    int n = 0;
    @(posedge sys_clk);
    araddr <= a;
    {arvalid, rready} <= 2'h3;
    do begin
      @(posedge sys_clk);
      if (arready) arvalid <= 1'b0;
      n++;
    end while (!rvalid && n < 200);
    d = {rresp, rdata};
    rready <= 1'b0;
    if (n >= 200) timeout_hit();
  endtask
  task automatic rdc(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e, input logic [1:0] er);
    logic [33:0] d;
    rd(a, d);
    check({d[33:32], d[31:0] & m}, {er, e});
  endtask
  task automatic wait_clear(input logic [31:0] m);
    logic [33:0] d;
    int n = 0;
    do begin
      rd(REG_STATUS, d);
      n++;
    end while ((d[31:0] & m) !== 32'h0 && n < 300);
    if (n >= 300) timeout_hit();
  endtask
  task automatic cmd(input logic [3:0] op, input logic [1:0] bk, input logic [12:0] ad);
    wr(REG_CMD, {13'h0, ad, bk, op}, RESP_OKAY);
    wait_clear(32'h1);
  endtask
  task automatic refused;
    rdc(REG_STATUS, 32'h2, 32'h2, RESP_OKAY);
    wr(REG_STATUS, 32'h2, RESP_OKAY);
  endtask
  initial begin
    logic [12:0] good [5] = '{13'h0032, 13'h004b, 13'h1e73, 13'h0652, 13'h0142};
    logic [12:0] bad [3] = '{13'h00c2, 13'h0041, 13'h0022};
    repeat (10) @(posedge sys_clk);
    rstn <= 1'b1;
    repeat (3) @(posedge sys_clk);
    rdc(REG_STATUS, 32'hff, 32'h0, RESP_OKAY);
    rdc(8'h20, 32'hffffffff, 32'h0, RESP_SLVERR);
    wr(REG_MODE, 32'h1, RESP_SLVERR);
    foreach (bad[i]) begin
      cmd(OP_MODE_LOAD, 2'h0, bad[i]);
      refused();
      check(mode_r, 13'h0000);
    end
    foreach (good[i]) begin
      cmd(OP_MODE_LOAD, 2'h0, good[i]);
      check(mode_r, good[i] & 13'h1eff);
      rdc(REG_MODE, 32'h1fff, {19'h0, good[i] & 13'h1eff}, RESP_OKAY);
    end
    cmd(OP_MODE_LOAD, 2'h1, 13'h0000);
    check(mode_r, 13'h0042);
    rdc(REG_STATUS, 32'h9, 32'h8, RESP_OKAY);
    cmd(OP_ACTIVATE, 2'h1, 13'h0123);
    rdc(REG_STATUS, 32'hf2, 32'h20, RESP_OKAY);
    for (int i = 0; i < 3; i++) begin
      cmd(i == 0 ? OP_ACTIVATE : OP_READ, i == 1 ? 2'h2 : 2'h1, 13'h0000);
      refused();
    end
    wait_clear(32'h8);
    wr(REG_WDATA, 32'h0000_1111, RESP_OKAY);
    cmd(OP_WRITE, 2'h1, 13'h0000);
    wr(REG_WDATA, 32'h0002_a5c3, RESP_OKAY);
    cmd(OP_WRITE, 2'h1, 13'h0000);
    cmd(OP_READ, 2'h1, 13'h0000);
    rdc(REG_RDATA, 32'hffffffff, 32'h11c3_11c3, RESP_OKAY);
    check(open_r, 4'h2);
    cmd(OP_REFRESH, 2'h0, 13'h0000);
    refused();
    cmd(OP_PRECHARGE, 2'h0, 13'h0000);
    cmd(OP_PRECHARGE, 2'h0, 13'h0400);
    rdc(REG_STATUS, 32'hf2, 32'h0, RESP_OKAY);
    cmd(OP_REFRESH, 2'h0, 13'h1fff);
    rdc(REG_STATUS, 32'h2, 32'h0, RESP_OKAY);
    cmd(OP_SELF_ENTER, 2'h0, 13'h0000);
    rdc(REG_STATUS, 32'h4, 32'h4, RESP_OKAY);
    check(cke, 1'b0);
    cmd(OP_SELF_EXIT, 2'h0, 13'h0000);
    rdc(REG_STATUS, 32'h6, 32'h0, RESP_OKAY);
    check(beat_col(3'h3, 3'h4, 1'b0, 1'b1), 34'h7);
    check(beat_col(3'h5, 3'h2, 1'b1, 1'b1), 34'h7);
    check(beat_col(3'h7, 3'h1, 1'b0, 1'b0), 34'h4);
    wr(REG_CFG, 32'h5, RESP_OKAY);
    rdc(REG_CFG, 32'hffffffff, 32'h5, RESP_OKAY);
    check(viol, 0);
    summarize();
  end
endmodule
